// ### rtl/low_power_mode_sequencer.sv
// What this block does
// - Standby entry: clock output pin low 32 to 45 cycles after idle.
// - Keep system clock 32 cycles, or 64 with halve select, before stopping.
// - Standby gates peripheral clocks; PLL and watchdog keep running.
// - Standby wake resumes within 100 cycles, or 1125 from sleeping flash.
// - After exit, service the waking interrupt only when it is enabled.
// - Halt after flush: stop oscillator to core, gate peripherals, stop PLL.
// - Halt with crystal or resonator also powers down the oscillator.
// - Falling wake pin in halt restarts the oscillator.
// - After oscillator stable, count 131072 oscillator cycles for PLL lock.
// - Then enable clocks; resume within 1125 cycles, or 35 from RAM.
// - Halt entry: clock output pin low within 45 cycles of idle.
// - Standby wake needs 3 oscillator cycles low, or 2 plus qualify count.
`include "lpm_seq_defines.svh"

module low_power_mode_sequencer #(
    parameter int unsigned PLL_LOCK_CYC = `PLL_LOCK_OSC_CYC,
    parameter int unsigned OSC_DIV = `OSC_DIV_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_idle_exec,
    input wire logic i_low_power_control_word_halt,
    input wire logic i_input_clock_halve_select,
    input wire logic i_standby_wake_qualify_en,
    input wire lpm_seq_pkg::qual_count_t i_standby_wake_qualify_count,
    input wire logic i_flash_asleep,
    input wire logic i_wake_int_enable,
    input wire logic i_crystal_source,
    input wire logic i_wake_pin_n,
    input wire logic i_external_reset_pin_n,
    input wire logic i_osc_stable,
    output logic o_clock_output_pin_enable,
    output logic o_system_clock_enable,
    output logic o_core_clock_enable,
    output logic o_periph_clock_enable,
    output logic o_watchdog_clock_enable,
    output logic o_pll_enable,
    output logic o_osc_to_core_enable,
    output logic o_osc_power_on,
    output logic o_resume_exec,
    output logic o_service_wake_int,
    output logic o_in_standby,
    output logic o_in_halt
);
    import lpm_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and oscillator tick

    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic wake_low;
    logic ext_rst_low;
    logic osc_ok;
    logic [`OSC_DIV_W-1:0] div_q;
    logic [`OSC_DIV_W-1:0] div_d;
    logic osc_tick;

    // Pins idle high after reset so no false wake is seen
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sync1_q <= 3'h3;
            sync2_q <= 3'h3;
        end else begin
            sync1_q <= {i_osc_stable, i_external_reset_pin_n, i_wake_pin_n};
            sync2_q <= sync1_q;
        end
    end

    assign wake_low = ~sync2_q[0];
    assign ext_rst_low = ~sync2_q[1];
    assign osc_ok = sync2_q[2];

    // Oscillator rate as an enable; the sequencer clock itself never stops
    assign osc_tick = (div_q == '0);
    assign div_d = (div_q == `OSC_DIV_W'(OSC_DIV - 1)) ? '0 : `OSC_DIV_W'(div_q + `OSC_DIV_W'(1));

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    lpm_state_e state_q;
    lpm_state_e state_d;
    count_t cnt_q;
    count_t cnt_d;
    logic halt_mode_q;
    logic flash_slow_q;
    logic crystal_q;
    logic qual_wake;
    logic idle_take;
    logic clkout_hit;
    logic flush_done;
    logic lock_done;
    logic resume_done;
    logic counting;
    logic halt_group;
    logic qual_arm;
    count_t flush_len;
    count_t resume_lim;

    assign idle_take = (state_q == ST_RUN) && i_idle_exec && !ext_rst_low;
    assign flush_len = i_input_clock_halve_select ? count_t'(`FLUSH_LONG_CYC)
                                                  : count_t'(`FLUSH_SHORT_CYC);
    // Compares lead by two: one for the count start, one for the output register
    assign clkout_hit = (state_q == ST_FLUSH) && (cnt_q == count_t'(`CLKOUT_LOW_CYC - 2));
    assign flush_done = (state_q == ST_FLUSH) && (cnt_q == count_t'(flush_len - count_t'(2)));
    assign lock_done = (state_q == ST_PLL_LOCK) && osc_tick
                       && (cnt_q == count_t'(PLL_LOCK_CYC - 1));
    assign resume_lim = halt_mode_q
        ? (flash_slow_q ? count_t'(`HALT_RESUME_SLOW_CYC) : count_t'(`HALT_RESUME_FAST_CYC))
        : (flash_slow_q ? count_t'(`STBY_RESUME_SLOW_CYC) : count_t'(`STBY_RESUME_FAST_CYC));
    assign resume_done = (state_q == ST_RESUME)
                         && (cnt_q == count_t'(resume_lim - count_t'(`RESUME_MARGIN_CYC)));
    assign qual_arm = !halt_mode_q && (state_q == ST_FLUSH || state_q == ST_STANDBY);

    wake_qualifier u_wake_qualifier (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_osc_tick(osc_tick),
        .i_arm(qual_arm),
        .i_wake_low(wake_low),
        .i_qualify_en(i_standby_wake_qualify_en),
        .i_qualify_count(i_standby_wake_qualify_count),
        .o_wake(qual_wake)
    );

    always_comb begin
        state_d = state_q;
        if (ext_rst_low) begin
            // External reset pulls the sequencer out of any mode
            state_d = ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (idle_take) begin
                        state_d = ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    if (flush_done) begin
                        state_d = halt_mode_q ? ST_HALT : ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (qual_wake) begin
                        state_d = ST_RESUME;
                    end
                end
                ST_HALT: begin
                    if (wake_low) begin
                        state_d = ST_OSC_WAIT;
                    end
                end
                ST_OSC_WAIT: begin
                    if (osc_ok) begin
                        state_d = ST_PLL_LOCK;
                    end
                end
                ST_PLL_LOCK: begin
                    if (lock_done) begin
                        state_d = ST_RESUME;
                    end
                end
                ST_RESUME: begin
                    if (resume_done) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    // Lock counts oscillator ticks; flush and resume count system cycles
    assign counting = (state_q == ST_FLUSH) || (state_q == ST_RESUME)
                      || ((state_q == ST_PLL_LOCK) && osc_tick);
    assign cnt_d = (state_d != state_q) ? '0 : counting ? count_t'(cnt_q + count_t'(1)) : cnt_q;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q <= ST_RUN;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Mode, clock source and flash state held for the whole episode
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            halt_mode_q <= 1'b0;
            flash_slow_q <= 1'b0;
            crystal_q <= 1'b0;
        end else if (idle_take) begin
            halt_mode_q <= i_low_power_control_word_halt;
            flash_slow_q <= i_flash_asleep;
            crystal_q <= i_crystal_source;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock and power controls, all registered

    logic sys_d;
    logic clkout_q;
    logic clkout_d;
    logic sys_q;
    logic core_q;
    logic periph_q;
    logic wdog_q;
    logic pll_q;
    logic pll_d;
    logic osc_core_q;
    logic osc_pwr_q;
    logic osc_pwr_d;
    logic resume_q;
    logic service_q;
    logic standby_q;
    logic halt_q;

    assign halt_group = (state_d == ST_HALT) || (state_d == ST_OSC_WAIT) || (state_d == ST_PLL_LOCK);
    assign sys_d = !halt_group && (state_d != ST_STANDBY);
    // Clock output pin drops on its own count, before a long flush ends
    assign clkout_d = (state_d == ST_FLUSH) ? (clkout_q && !clkout_hit) : sys_d;
    assign pll_d = !((state_d == ST_HALT) || (state_d == ST_OSC_WAIT));
    assign osc_pwr_d = !((state_d == ST_HALT) && crystal_q);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            clkout_q <= 1'b1;
            sys_q <= 1'b1;
            core_q <= 1'b1;
            periph_q <= 1'b1;
            wdog_q <= 1'b1;
            pll_q <= 1'b1;
            osc_core_q <= 1'b1;
            osc_pwr_q <= 1'b1;
        end else begin
            clkout_q <= clkout_d;
            sys_q <= sys_d;
            core_q <= sys_d;
            periph_q <= sys_d;
            wdog_q <= !halt_group;
            pll_q <= pll_d;
            osc_core_q <= !halt_group;
            osc_pwr_q <= osc_pwr_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            resume_q <= 1'b0;
            service_q <= 1'b0;
            standby_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            resume_q <= resume_done && !ext_rst_low;
            service_q <= resume_done && !ext_rst_low && i_wake_int_enable;
            standby_q <= (state_d == ST_STANDBY);
            halt_q <= (state_d == ST_HALT);
        end
    end

    assign o_clock_output_pin_enable = clkout_q;
    assign o_system_clock_enable = sys_q;
    assign o_core_clock_enable = core_q;
    assign o_periph_clock_enable = periph_q;
    assign o_watchdog_clock_enable = wdog_q;
    assign o_pll_enable = pll_q;
    assign o_osc_to_core_enable = osc_core_q;
    assign o_osc_power_on = osc_pwr_q;
    assign o_resume_exec = resume_q;
    assign o_service_wake_int = service_q;
    assign o_in_standby = standby_q;
    assign o_in_halt = halt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions (bench keeps the external reset pin high around entry)

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst || ext_rst_low);

    property p_clkout_standby;
        idle_take |-> ##31 o_clock_output_pin_enable ##[1:14] !o_clock_output_pin_enable;
    endproperty
    a_clkout_standby: assert property (p_clkout_standby) else $error("clock output pin low outside 32..45");

    property p_clkout_halt;
        idle_take && i_low_power_control_word_halt |-> ##[1:45] !o_clock_output_pin_enable;
    endproperty
    a_clkout_halt: assert property (p_clkout_halt) else $error("clock output pin not low by 45 in halt");

    property p_flush_short;
        idle_take && !i_input_clock_halve_select |-> ##31 o_system_clock_enable ##1 !o_system_clock_enable;
    endproperty
    a_flush_short: assert property (p_flush_short) else $error("system clock not held exactly 32");

    property p_flush_long;
        idle_take && i_input_clock_halve_select |-> ##63 o_system_clock_enable ##1 !o_system_clock_enable;
    endproperty
    a_flush_long: assert property (p_flush_long) else $error("system clock not held exactly 64");

    property p_standby_clocks;
        o_in_standby |-> !o_periph_clock_enable && o_pll_enable && o_watchdog_clock_enable;
    endproperty
    a_standby_clocks: assert property (p_standby_clocks) else $error("standby clock gating wrong");

    property p_halt_clocks;
        o_in_halt |-> !o_osc_to_core_enable && !o_periph_clock_enable && !o_pll_enable;
    endproperty
    a_halt_clocks: assert property (p_halt_clocks) else $error("halt clock gating wrong");

    property p_halt_osc_off;
        o_in_halt && crystal_q |-> !o_osc_power_on;
    endproperty
    a_halt_osc_off: assert property (p_halt_osc_off) else $error("crystal oscillator left on in halt");

    property p_halt_wake_osc;
        state_q == ST_HALT && wake_low |=> o_osc_power_on && !o_in_halt;
    endproperty
    a_halt_wake_osc: assert property (p_halt_wake_osc) else $error("wake pin did not restart oscillator");

    property p_lock_clocks;
        state_q == ST_PLL_LOCK |-> (!o_core_clock_enable and (lock_done |=> o_core_clock_enable));
    endproperty
    a_lock_clocks: assert property (p_lock_clocks) else $error("clocks wrong around pll lock count");

    property p_standby_resume_fast;
        state_q == ST_STANDBY && qual_wake && !flash_slow_q |-> ##[1:100] o_resume_exec;
    endproperty
    a_standby_resume_fast: assert property (p_standby_resume_fast) else $error("standby resume over 100");

    property p_halt_resume_ram;
        lock_done && !flash_slow_q |-> ##[1:35] o_resume_exec;
    endproperty
    a_halt_resume_ram: assert property (p_halt_resume_ram) else $error("halt resume over 35");

    property p_service_gate;
        o_service_wake_int |-> o_resume_exec && $past(i_wake_int_enable);
    endproperty
    a_service_gate: assert property (p_service_gate) else $error("disabled wake interrupt serviced");
endmodule

// ### rtl/lpm_seq_defines.svh
`ifndef LPM_SEQ_DEFINES_SVH
`define LPM_SEQ_DEFINES_SVH

// Entry timing, system clock cycles from the idle instruction
`define CLKOUT_LOW_CYC 32
`define FLUSH_SHORT_CYC 32
`define FLUSH_LONG_CYC 64

// Resume latency limits, system clock cycles
`define STBY_RESUME_FAST_CYC 100
`define STBY_RESUME_SLOW_CYC 1125
`define HALT_RESUME_FAST_CYC 35
`define HALT_RESUME_SLOW_CYC 1125
// Margin kept below each limit for the registered pulse
`define RESUME_MARGIN_CYC 2

// Oscillator clock cycle counts
`define PLL_LOCK_OSC_CYC 131072
`define WAKE_PLAIN_OSC_CYC 3
`define WAKE_QUAL_BASE_OSC_CYC 2
`define OSC_DIV_DEFAULT 1

// Widths
`define QUAL_COUNT_W 6
`define QUAL_RUN_W 7
`define CNT_W 18
`define OSC_DIV_W 8

`endif

// ### rtl/lpm_seq_pkg.sv
`include "lpm_seq_defines.svh"

package lpm_seq_pkg;
    typedef enum logic [2:0] {
        ST_RUN      = 3'h0,
        ST_FLUSH    = 3'h1,
        ST_STANDBY  = 3'h3,
        ST_RESUME   = 3'h2,
        ST_HALT     = 3'h5,
        ST_OSC_WAIT = 3'h7,
        ST_PLL_LOCK = 3'h6
    } lpm_state_e;

    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`QUAL_COUNT_W-1:0] qual_count_t;
    typedef logic [`QUAL_RUN_W-1:0] qual_run_t;
endpackage

// ### rtl/wake_qualifier.sv
`include "lpm_seq_defines.svh"

module wake_qualifier (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_osc_tick,
    input wire logic i_arm,
    input wire logic i_wake_low,
    input wire logic i_qualify_en,
    input wire lpm_seq_pkg::qual_count_t i_qualify_count,
    output logic o_wake
);
    import lpm_seq_pkg::*;

    qual_run_t run_q;
    qual_run_t run_d;
    qual_run_t need;
    qual_run_t run_inc;
    logic wake_q;
    logic wake_d;

    // Low time needed, in oscillator ticks
    assign need = i_qualify_en ? qual_run_t'(`WAKE_QUAL_BASE_OSC_CYC) + qual_run_t'(i_qualify_count)
                               : qual_run_t'(`WAKE_PLAIN_OSC_CYC);
    assign run_inc = qual_run_t'(run_q + qual_run_t'(1));
    // A high sample restarts the count; stops at need so it cannot wrap
    assign run_d = (!i_arm || !i_wake_low) ? '0 :
                   (i_osc_tick && run_q < need) ? run_inc : run_q;
    // Sticky while armed so a wake seen during flush is not lost
    assign wake_d = i_arm && (wake_q || (i_osc_tick && i_wake_low && run_inc >= need));
    assign o_wake = wake_q;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            run_q <= '0;
            wake_q <= 1'b0;
        end else begin
            run_q <= run_d;
            wake_q <= wake_d;
        end
    end

    property p_qualify_len;
        @(posedge i_clock) disable iff (i_srst)
        $rose(wake_q) |-> run_q == $past(need);
    endproperty
    a_qualify_len: assert property (p_qualify_len) else $error("wake accepted at wrong low length");
endmodule

// ### verif/wake_source.sv
// Wake source on the far side; both pins idle high through pull-ups
module wake_source (
    input wire logic i_clock,
    input wire logic i_go,
    input wire logic i_use_reset,
    input wire logic i_osc_stable,
    input wire logic [7:0] i_low_cycles,
    output logic o_wake_pin_n,
    output logic o_external_reset_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_wake_pin_n = 1'b1;
        o_external_reset_pin_n = 1'b1;
        forever begin
            @(posedge i_clock);
            if (i_go) begin
                repeat (4) @(posedge i_clock);
                #2;
                if (i_use_reset) o_external_reset_pin_n = 1'b0;
                else o_wake_pin_n = 1'b0;
                repeat (i_low_cycles) @(posedge i_clock);
                // Oscillator must settle before a clean release
                while (!i_osc_stable) @(posedge i_clock);
                repeat (i_use_reset ? 8 : 2) @(posedge i_clock);
                #2;
                o_wake_pin_n = 1'b1;
                o_external_reset_pin_n = 1'b1;
            end
        end
    end
endmodule

// ### verif/tb_low_power_mode_sequencer.sv
module tb_low_power_mode_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    import lpm_seq_pkg::*;

    logic clk, srst, idle, halt_mode, halve, qen, flash, inten, crystal, osc_stable, go, use_reset;
    qual_count_t qcnt;
    logic [7:0] low_cycles;
    logic wake_n, rst_n;
    logic clkout_en, sys_en, core_en, periph_en, wdog_en, pll_en, osc_core_en, osc_pwr;
    logic resume, svc, in_stby, in_halt;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////
    // Short lock count keeps the halt runs brief
    low_power_mode_sequencer #(.PLL_LOCK_CYC(16), .OSC_DIV(1)) i_low_power_mode_sequencer (
        .i_clock(clk),
        .i_srst(srst),
        .i_idle_exec(idle),
        .i_low_power_control_word_halt(halt_mode),
        .i_input_clock_halve_select(halve),
        .i_standby_wake_qualify_en(qen),
        .i_standby_wake_qualify_count(qcnt),
        .i_flash_asleep(flash),
        .i_wake_int_enable(inten),
        .i_crystal_source(crystal),
        .i_wake_pin_n(wake_n),
        .i_external_reset_pin_n(rst_n),
        .i_osc_stable(osc_stable),
        .o_clock_output_pin_enable(clkout_en),
        .o_system_clock_enable(sys_en),
        .o_core_clock_enable(core_en),
        .o_periph_clock_enable(periph_en),
        .o_watchdog_clock_enable(wdog_en),
        .o_pll_enable(pll_en),
        .o_osc_to_core_enable(osc_core_en),
        .o_osc_power_on(osc_pwr),
        .o_resume_exec(resume),
        .o_service_wake_int(svc),
        .o_in_standby(in_stby),
        .o_in_halt(in_halt)
    );

    wake_source i_wake_source (
        .i_clock(clk),
        .i_go(go),
        .i_use_reset(use_reset),
        .i_osc_stable(osc_stable),
        .i_low_cycles(low_cycles),
        .o_wake_pin_n(wake_n),
        .o_external_reset_pin_n(rst_n)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc >= 10000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #2;
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return clkout_en;
            1: return sys_en;
            2: return resume;
            3: return core_en;
            4: return osc_pwr;
            5: return wake_n;
            6: return in_halt;
            default: return rst_n;
        endcase
    endfunction

    // Bounded wait; n counts edges so far
    task automatic wait_lvl(input int sel, input logic lvl, input int lim, inout int n);
        while (sig(sel) !== lvl && n < lim) begin
            step();
            n++;
        end
    endtask

    task automatic fire_idle(input logic hm, input logic hv, input logic fl, input logic cr);
        repeat (3) step();
        halt_mode = hm;
        halve = hv;
        flash = fl;
        crystal = cr;
        idle = 1'b1;
        step();
        idle = 1'b0;
    endtask

    task automatic kick(input logic ur, input logic [7:0] w);
        use_reset = ur;
        low_cycles = w;
        go = 1'b1;
        step();
        go = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic scen_standby(input logic hv, input logic fl, input logic ie, input logic qe, input int q,
                                input int lim);
        int n;
        int w;
        // Idle cycle itself is cycle 0, so the first sample is cycle 1
        n = 1;
        w = qe ? q + 2 : 3;
        qen = qe;
        qcnt = q[5:0];
        inten = ie;
        fire_idle(1'b0, hv, fl, 1'b0);
        wait_lvl(0, 1'b0, 60, n);
        chk_rng(n, 32, 45);
        wait_lvl(1, 1'b0, 80, n);
        chk_rng(n, hv ? 64 : 32, hv ? 65 : 33);
        step();
        chk(periph_en, 1'b0);
        chk(pll_en, 1'b1);
        chk(wdog_en, 1'b1);
        chk(in_stby, 1'b1);
        // A second idle while asleep must be ignored
        fire_idle(1'b1, hv, fl, 1'b1);
        chk(in_halt, 1'b0);
        kick(1'b0, 8'(w));
        // Pin falls four edges after go; reading it here would race the source
        repeat (4) step();
        n = 0;
        wait_lvl(2, 1'b1, lim + 80, n);
        chk_rng(n, 98 + w, lim + w + 3);
        chk(svc, ie);
        chk(core_en, 1'b1);
    endtask

    task automatic scen_halt(input logic cr, input logic fl, input int lim);
        int n;
        n = 1;
        fire_idle(1'b1, 1'b0, fl, cr);
        wait_lvl(0, 1'b0, 60, n);
        chk_rng(n, 1, 45);
        wait_lvl(6, 1'b1, 80, n);
        chk(osc_core_en, 1'b0);
        chk(periph_en, 1'b0);
        chk(pll_en, 1'b0);
        chk(osc_pwr, !cr);
        osc_stable = 1'b0;
        kick(1'b0, 8'h02);
        repeat (4) step();
        n = 0;
        wait_lvl(4, 1'b1, 20, n);
        chk_rng(n, 0, 4);
        repeat (10) step();
        osc_stable = 1'b1;
        n = 0;
        wait_lvl(3, 1'b1, 60, n);
        chk_rng(n, 16, 24);
        chk(periph_en, 1'b1);
        n = 0;
        wait_lvl(2, 1'b1, 1200, n);
        chk_rng(n, 1, lim);
    endtask

    task automatic scen_halt_reset();
        int n;
        n = 1;
        fire_idle(1'b1, 1'b1, 1'b0, 1'b1);
        wait_lvl(6, 1'b1, 80, n);
        chk_rng(n, 64, 65);
        osc_stable = 1'b0;
        kick(1'b1, 8'h04);
        repeat (4) step();
        n = 0;
        wait_lvl(6, 1'b0, 20, n);
        chk_rng(n, 1, 4);
        chk(core_en, 1'b1);
        chk(osc_pwr, 1'b1);
        repeat (6) step();
        osc_stable = 1'b1;
        n = 0;
        wait_lvl(7, 1'b1, 40, n);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        idle = 1'b0;
        halt_mode = 1'b0;
        halve = 1'b0;
        qen = 1'b0;
        qcnt = '0;
        flash = 1'b0;
        inten = 1'b1;
        crystal = 1'b0;
        osc_stable = 1'b1;
        go = 1'b0;
        use_reset = 1'b0;
        low_cycles = 8'h03;
        repeat (10) @(posedge clk);
        #2;
        srst = 1'b0;
        chk(core_en, 1'b1);
        chk(resume, 1'b0);
        scen_standby(1'b0, 1'b0, 1'b1, 1'b0, 0, 100);
        scen_standby(1'b1, 1'b1, 1'b0, 1'b1, 20, 1125);
        scen_halt(1'b1, 1'b0, 35);
        scen_halt(1'b0, 1'b1, 1125);
        scen_halt_reset();
        end_sim();
    end
endmodule
